// ===== csd_defines.vh
// Constants for the chip select decoder: field positions, reset values and encodings
`ifndef CSD_DEFINES_VH
`define CSD_DEFINES_VH
`define CSD_NUM_CS        8
`define CSD_BASE_W        16
`define CSD_ADDR_HI       31
`define CSD_ADDR_LO       16
// Control word field positions
`define CSD_CTL_W         16
`define CSD_CTL_WAIT_LO   0
`define CSD_CTL_WAIT_HI   3
`define CSD_CTL_PS_LO     4
`define CSD_CTL_PS_HI     5
`define CSD_CTL_INT_ACK   6
`define CSD_CTL_EXT_ACK   7
`define CSD_CTL_BURST     8
`define CSD_CTL_SETUP     9
`define CSD_CTL_HOLD      10
`define CSD_CTL_RD_EN     11
`define CSD_CTL_WR_EN     12
`define CSD_CTL_BURST_CS  13
// Attribute mask word positions
`define CSD_ATR_W         5
`define CSD_ATR_SD        0
`define CSD_ATR_SC        1
`define CSD_ATR_UD        2
`define CSD_ATR_UC        3
`define CSD_ATR_CPU       4
// Port size encodings
`define CSD_PS_32         2'h0
`define CSD_PS_8          2'h1
`define CSD_PS_16         2'h2
// Boot select reset control: read/write, setup, hold, no burst, 15 waits, int ack
`define CSD_BOOT_CTL      16'h1E4F
// Decode result encodings
`define CSD_HIT_W         2
`define CSD_HIT_NONE      2'h0
`define CSD_HIT_CS        2'h1
`define CSD_HIT_DRAM      2'h2
`endif

// ===== csd_chip_select_decoder.v
// Chip select decoder with wait-state termination and setup/hold timing
`timescale 1ns/10ps
`include "csd_defines.vh"

// Behaviour
// - Eight banks with base, mask, control
// - Bank zero is global boot select
// - Bank one may assert on CPU space
// - No hit uses default space controls
// - Base compared with address bits 31-16
// - Masked bits skipped; all clear gives 64k
// - Priority banks 0-7, DRAM 0-1, default
// - Read and write allow per bank
// - Attribute masks; CPU mask only bank one
// - Assert needs match, direction, attribute
// - Wait counts zero to fifteen
// - Narrow ports on upper byte lanes
// - Internal, sync, async termination supported
// - Sync ack ends non-external transfer two clocks later
// - Device drives ack for external masters
// - Synchronised async ack ends transfer
// - Burst only when enabled and operand wider
// - Select asserts with strobe or one later
// - Select released after every beat; burst hold bit has no effect
// - Hold drives address one extra clock
// - Per-bank ack enable for external masters
// - First bank-zero mask write ends boot mode
// - Write enables one clock after select
module csd_chip_select_decoder (
  input  wire         core_clk_i,
  input  wire         arst_n_i,
  input  wire [127:0] select_base_reg_i,
  input  wire [127:0] select_mask_reg_i,
  input  wire [39:0]  select_attr_mask_i,
  input  wire [127:0] select_ctrl_reg_i,
  input  wire         select_mask0_wr_i,
  input  wire [15:0]  default_space_ctrl_reg_i,
  input  wire [31:0]  dram_base_reg_i,
  input  wire [31:0]  dram_mask_reg_i,
  input  wire         cycle_begin_strobe_i,
  input  wire [31:0]  xfer_addr_i,
  input  wire         xfer_write_i,
  input  wire         xfer_super_i,
  input  wire         xfer_code_i,
  input  wire         xfer_cpu_space_i,
  input  wire         xfer_ext_master_i,
  input  wire [1:0]   xfer_size_i,
  input  wire [1:0]   xfer_lane_i,
  input  wire         xfer_burst_last_i,
  input  wire         sync_xfer_ack_i,
  input  wire         async_xfer_ack_i,
  output reg  [7:0]   chip_sel_n_o,
  output reg  [3:0]   byte_we_n_o,
  output reg  [1:0]   dram_hit_o,
  output reg  [1:0]   port_size_field_o,
  output reg          burst_en_o,
  output wire         xfer_done_o,
  output reg          addr_drive_o,
  output wire         sync_xfer_ack_o,
  output wire         sync_xfer_ack_oe_o,
  output reg          boot_mode_o
);

  // ==========================================================================
  // State encodings
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_BUSY = 3'h2;
  localparam [2:0] ST_HOLD = 3'h4;

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg  [7:0]  sel_q;
  reg  [15:0] ctl_q;
  reg  [3:0]  wait_q;
  reg         write_q;
  reg         ext_q;
  reg         cs_on_q;
  reg         we_on_q;
  reg  [3:0]  lanes_q;
  reg         aack_s1_q;
  reg         aack_s2_q;
  reg         aack_s3_q;
  reg         sack_s1_q;
  reg         sack_s2_q;
  reg         mask0_s1_q;
  reg         mask0_s2_q;
  reg         mask0_s3_q;

  // ==========================================================================
  // Pin synchronisers; the first stage feeds only the second
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aack_s1_q  <= 1'b0;
      aack_s2_q  <= 1'b0;
      aack_s3_q  <= 1'b0;
      sack_s1_q  <= 1'b0;
      sack_s2_q  <= 1'b0;
      mask0_s1_q <= 1'b0;
      mask0_s2_q <= 1'b0;
      mask0_s3_q <= 1'b0;
    end else begin
      aack_s1_q  <= async_xfer_ack_i;
      aack_s2_q  <= aack_s1_q;
      aack_s3_q  <= aack_s2_q;
      sack_s1_q  <= sync_xfer_ack_i;
      sack_s2_q  <= sack_s1_q;
      mask0_s1_q <= select_mask0_wr_i;
      mask0_s2_q <= mask0_s1_q;
      mask0_s3_q <= mask0_s2_q;
    end
  end

  wire aack_rise  = aack_s2_q & ~aack_s3_q;
  wire mask0_rise = mask0_s2_q & ~mask0_s3_q;

  // ==========================================================================
  // Bank decode
  reg  [7:0] bank_hit;
  reg  [7:0] pick;
  reg  [1:0] dram_pick;
  reg  [1:0] hit_kind;
  reg  [15:0] ctl_sel;
  reg  [15:0] base_b;
  reg  [15:0] mask_b;
  reg  [4:0]  atr_b;
  reg  [15:0] dbase_b;
  reg  [15:0] dmask_b;
  reg         attr_ok;
  reg         dir_ok;
  reg         found;
  integer     i;

  always @* begin
    bank_hit  = 8'h00;
    pick      = 8'h00;
    dram_pick = 2'h0;
    hit_kind  = `CSD_HIT_NONE;
    ctl_sel   = default_space_ctrl_reg_i;
    found     = 1'b0;
    base_b    = 16'h0000;
    mask_b    = 16'h0000;
    atr_b     = 5'h00;
    dbase_b   = 16'h0000;
    dmask_b   = 16'h0000;
    attr_ok   = 1'b0;
    dir_ok    = 1'b0;
    for (i = 0; i < `CSD_NUM_CS; i = i + 1) begin
      base_b = select_base_reg_i[i*`CSD_BASE_W +: `CSD_BASE_W];
      mask_b = select_mask_reg_i[i*`CSD_BASE_W +: `CSD_BASE_W];
      atr_b  = select_attr_mask_i[i*`CSD_ATR_W +: `CSD_ATR_W];
      ctl_sel = select_ctrl_reg_i[i*`CSD_CTL_W +: `CSD_CTL_W];
      // Attribute check; CPU space mask exists on bank one only
      if (xfer_cpu_space_i)
        attr_ok = (i == 1) && !atr_b[`CSD_ATR_CPU];
      else if (xfer_super_i)
        attr_ok = xfer_code_i ? !atr_b[`CSD_ATR_SC] : !atr_b[`CSD_ATR_SD];
      else
        attr_ok = xfer_code_i ? !atr_b[`CSD_ATR_UC] : !atr_b[`CSD_ATR_UD];
      dir_ok = xfer_write_i ? ctl_sel[`CSD_CTL_WR_EN] : ctl_sel[`CSD_CTL_RD_EN];
      // Unmasked address bits only
      bank_hit[i] = (((xfer_addr_i[`CSD_ADDR_HI:`CSD_ADDR_LO] ^ base_b) & ~mask_b)
                     == 16'h0000) && dir_ok && attr_ok;
      // Global boot select claims all but CPU space, for allowed directions
      if (i == 0 && boot_mode_o)
        bank_hit[i] = !xfer_cpu_space_i && dir_ok;
    end
    ctl_sel = default_space_ctrl_reg_i;
    // Lowest numbered bank wins, then DRAM, then default
    for (i = `CSD_NUM_CS - 1; i >= 0; i = i - 1) begin
      if (bank_hit[i]) begin
        pick    = 8'h00;
        pick[i] = 1'b1;
        found   = 1'b1;
        ctl_sel = select_ctrl_reg_i[i*`CSD_CTL_W +: `CSD_CTL_W];
      end
    end
    if (found) begin
      hit_kind = `CSD_HIT_CS;
    end else begin
      for (i = 1; i >= 0; i = i - 1) begin
        dbase_b = dram_base_reg_i[i*`CSD_BASE_W +: `CSD_BASE_W];
        dmask_b = dram_mask_reg_i[i*`CSD_BASE_W +: `CSD_BASE_W];
        if ((((xfer_addr_i[`CSD_ADDR_HI:`CSD_ADDR_LO] ^ dbase_b) & ~dmask_b) == 16'h0000)
            && !xfer_cpu_space_i) begin
          dram_pick    = 2'h0;
          dram_pick[i] = 1'b1;
          hit_kind     = `CSD_HIT_DRAM;
        end
      end
    end
  end

  // ==========================================================================
  // Byte lanes: narrow ports sit on the upper data lanes
  reg [3:0] lanes_new;
  always @* begin
    case (ctl_sel[`CSD_CTL_PS_HI:`CSD_CTL_PS_LO])
      `CSD_PS_8:  lanes_new = 4'h8;
      `CSD_PS_16: lanes_new = xfer_size_i[0] ? (xfer_lane_i[0] ? 4'h4 : 4'h8) : 4'hC;
      default: begin
        case (xfer_size_i)
          2'h1:    lanes_new = 4'h8 >> xfer_lane_i;
          2'h2:    lanes_new = xfer_lane_i[1] ? 4'h3 : 4'hC;
          default: lanes_new = 4'hF;
        endcase
      end
    endcase
  end

  // ==========================================================================
  // Termination
  wire int_term  = ctl_q[`CSD_CTL_INT_ACK];
  wire wait_done = (wait_q == 4'h0);
  wire ext_ack   = ext_q ? aack_rise : (sack_s2_q | aack_rise);
  // Internal ack for external masters only when that bank allows it
  wire own_ack   = ext_q ? ctl_q[`CSD_CTL_EXT_ACK] : int_term;
  wire term      = (state_q == ST_BUSY) && (ext_ack || (own_ack && wait_done));

  assign xfer_done_o        = term;
  // Device drives sync ack during an external master access it terminates
  assign sync_xfer_ack_oe_o = (state_q == ST_BUSY) && ext_q && ctl_q[`CSD_CTL_EXT_ACK];
  // Ack is only driven out while the device owns the pin for an external master
  assign sync_xfer_ack_o    = term && sync_xfer_ack_oe_o;

  // Next state
  always @* begin
    case (state_q)
      ST_IDLE: state_d = cycle_begin_strobe_i ? ST_BUSY : ST_IDLE;
      ST_BUSY: begin
        if (term)
          state_d = ctl_q[`CSD_CTL_HOLD] ? ST_HOLD : ST_IDLE;
        else
          state_d = ST_BUSY;
      end
      ST_HOLD: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // ==========================================================================
  // Transfer registers and output timing
  always @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q           <= ST_IDLE;
      sel_q             <= 8'h00;
      ctl_q             <= 16'h0000;
      wait_q            <= 4'h0;
      write_q           <= 1'b0;
      ext_q             <= 1'b0;
      cs_on_q           <= 1'b0;
      we_on_q           <= 1'b0;
      lanes_q           <= 4'h0;
      chip_sel_n_o      <= 8'hFF;
      byte_we_n_o       <= 4'hF;
      dram_hit_o        <= 2'h0;
      port_size_field_o <= `CSD_PS_32;
      burst_en_o        <= 1'b0;
      addr_drive_o      <= 1'b0;
      boot_mode_o       <= 1'b1;
    end else begin
      state_q <= state_d;
      // Boot mode ends for good on the first bank-zero mask write
      if (mask0_rise)
        boot_mode_o <= 1'b0;
      if (state_q == ST_IDLE && cycle_begin_strobe_i) begin
        sel_q   <= pick;
        ctl_q   <= ctl_sel;
        wait_q  <= ctl_sel[`CSD_CTL_WAIT_HI:`CSD_CTL_WAIT_LO];
        write_q <= xfer_write_i;
        ext_q   <= xfer_ext_master_i;
        lanes_q <= lanes_new;
        port_size_field_o <= ctl_sel[`CSD_CTL_PS_HI:`CSD_CTL_PS_LO];
        // Burst only when enabled and operand wider than port
        burst_en_o <= ctl_sel[`CSD_CTL_BURST] &&
                      ((ctl_sel[`CSD_CTL_PS_HI:`CSD_CTL_PS_LO] == `CSD_PS_8
                        && xfer_size_i != 2'h1) ||
                       (ctl_sel[`CSD_CTL_PS_HI:`CSD_CTL_PS_LO] == `CSD_PS_16
                        && (xfer_size_i == 2'h0 || xfer_size_i == 2'h3)));
        dram_hit_o   <= (hit_kind == `CSD_HIT_DRAM) ? dram_pick : 2'h0;
        addr_drive_o <= ~xfer_ext_master_i;
        // Select with the strobe, or one clock later under setup
        cs_on_q      <= 1'b1;
        chip_sel_n_o <= ctl_sel[`CSD_CTL_SETUP] ? 8'hFF : ~pick;
        we_on_q      <= 1'b0;
      end else if (state_q == ST_BUSY) begin
        if (wait_q != 4'h0)
          wait_q <= wait_q - 4'h1;
        chip_sel_n_o <= ~sel_q;
        // Write enables follow select by one clock
        byte_we_n_o  <= (write_q && cs_on_q && !chip_sel_n_o[0] | (chip_sel_n_o != 8'hFF))
                        ? ~lanes_q : 4'hF;
        // Burst beats drop select; the term release below overrides the hold bit
        if (!ctl_q[`CSD_CTL_BURST_CS] && xfer_burst_last_i == 1'b0 && burst_en_o && term)
          chip_sel_n_o <= 8'hFF;
        if (term) begin
          chip_sel_n_o <= 8'hFF;
          byte_we_n_o  <= 4'hF;
          cs_on_q      <= 1'b0;
          if (!ctl_q[`CSD_CTL_HOLD]) begin
            addr_drive_o <= 1'b0;
            dram_hit_o   <= 2'h0;
          end
        end
      end else begin
        // Hold keeps the address driven one extra clock, released here
        addr_drive_o <= 1'b0;
        dram_hit_o   <= 2'h0;
        chip_sel_n_o <= 8'hFF;
        byte_we_n_o  <= 4'hF;
        cs_on_q      <= 1'b0;
        we_on_q      <= 1'b0;
      end
    end
  end

endmodule // csd_chip_select_decoder

// ===== csd_ext_mem_model.sv
// Far-side memory model answering transfers with acknowledges
`timescale 1ns/10ps
// ==========================================
// Memory model
module csd_ext_mem_model (
  input  wire       core_clk_i,
  input  wire [7:0] sel_n_i,
  input  wire [1:0] mode_i,
  input  wire       ext_i,
  output reg        sync_ack_o = 1'b0,
  output reg        async_ack_o = 1'b0
);
  // Ack one clock after select, idle low once deselected
  always @(posedge core_clk_i) begin
    sync_ack_o <= mode_i == 2'h1 && !ext_i && sel_n_i != 8'hFF;
    async_ack_o <= mode_i == 2'h2 && sel_n_i != 8'hFF;
  end
endmodule // csd_ext_mem_model

// ===== csd_chip_select_decoder_properties.sv
// Port assertions for the chip select decoder
`timescale 1ns/10ps
// ==========================================
// Checker
module csd_chip_select_decoder_properties (
  input wire       core_clk_i,
  input wire       arst_n_i,
  input wire       select_mask0_wr_i,
  input wire [7:0] chip_sel_n_o,
  input wire [3:0] byte_we_n_o,
  input wire [1:0] dram_hit_o,
  input wire       xfer_done_o,
  input wire       sync_xfer_ack_o,
  input wire       sync_xfer_ack_oe_o,
  input wire       boot_mode_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Steps of a transfer
  sequence s_end; xfer_done_o; endsequence
  sequence s_sel_fall; $fell(&chip_sel_n_o); endsequence
  a_done_single: assert property (s_end |=> !xfer_done_o) else $error("done too long");
  a_sel_release: assert property (s_end |=> &chip_sel_n_o) else $error("select held");
  a_sel_to_done: assert property (s_sel_fall |-> ##[0:18] xfer_done_o)
    else $error("no done after select");
  a_sel_onehot: assert property ($onehot0(~chip_sel_n_o)) else $error("two selects");
  a_dram_no_sel: assert property (|dram_hit_o |-> &chip_sel_n_o)
    else $error("select with dram hit");
  a_we_after_sel: assert property (!(&byte_we_n_o) |-> !(&$past(chip_sel_n_o)))
    else $error("enable before select");
  a_ack_has_oe: assert property (sync_xfer_ack_o |-> sync_xfer_ack_oe_o)
    else $error("ack not driven");
  a_boot_clear: assert property ($rose(select_mask0_wr_i) |-> ##[1:5] !boot_mode_o)
    else $error("boot mode stays");
  a_boot_sticky: assert property (!boot_mode_o |=> !boot_mode_o)
    else $error("boot mode back");
endmodule // csd_chip_select_decoder_properties

bind csd_chip_select_decoder csd_chip_select_decoder_properties u_chk (.core_clk_i,
  .arst_n_i, .select_mask0_wr_i, .chip_sel_n_o, .byte_we_n_o, .dram_hit_o,
  .xfer_done_o, .sync_xfer_ack_o, .sync_xfer_ack_oe_o, .boot_mode_o);

// ===== tb_top.sv
// Self-checking bench for the chip select decoder
`timescale 1ns/10ps
`include "csd_defines.vh"
// ==========================================
// Bench top
module tb_top;
  reg          clk = 1'b0;
  reg          rst_n, stb, m0wr, bz, oe, hd;
  reg  [127:0] base, msk, ctl;
  reg  [39:0]  atr;
  reg  [31:0]  addr, dbase;
  reg  [15:0]  dctl;
  reg  [7:0]   sl;
  reg  [4:0]   at;
  reg  [3:0]   wv;
  reg  [1:0]   sz, mode, pz, dv;
  wire [7:0]   sel;
  wire [3:0]   we;
  wire [1:0]   dh, ps;
  wire         bu, done, ad, sao, aoe, boot, sack, aack;
  integer      ts, td, n, err_count, checks_done;
  // Clock, 25 ns period
  always #12.5 clk = ~clk;
  // Device and far-side memory
  csd_chip_select_decoder u_dut (.core_clk_i(clk), .arst_n_i(rst_n),
    .select_base_reg_i(base), .select_mask_reg_i(msk), .select_attr_mask_i(atr),
    .select_ctrl_reg_i(ctl), .select_mask0_wr_i(m0wr), .default_space_ctrl_reg_i(dctl),
    .dram_base_reg_i(dbase), .dram_mask_reg_i(32'h0), .cycle_begin_strobe_i(stb),
    .xfer_addr_i(addr), .xfer_write_i(at[0]), .xfer_super_i(at[1]), .xfer_code_i(at[2]),
    .xfer_cpu_space_i(at[3]), .xfer_ext_master_i(at[4]), .xfer_size_i(sz),
    .xfer_lane_i(addr[1:0]), .xfer_burst_last_i(1'b1), .sync_xfer_ack_i(sack),
    .async_xfer_ack_i(aack), .chip_sel_n_o(sel), .byte_we_n_o(we), .dram_hit_o(dh),
    .port_size_field_o(ps), .burst_en_o(bu), .xfer_done_o(done), .addr_drive_o(ad),
    .sync_xfer_ack_o(sao), .sync_xfer_ack_oe_o(aoe), .boot_mode_o(boot));
  csd_ext_mem_model u_mem (.core_clk_i(clk), .sel_n_i(sel), .mode_i(mode), .ext_i(at[4]),
    .sync_ack_o(sack), .async_ack_o(aack));
  // Compare and count
  task chk(input [63:0] nm, input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("unexpected %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // One transfer from a falling edge; records selects, enables and timing
  task xfer(input [31:0] a, input [4:0] t, input [1:0] s);
    integer i;
    begin
      {addr, at, sz, stb} = {a, t, s, 1'b1};
      @(negedge clk);
      {stb, sl, wv, oe, dv, pz, bz, ts, td} = {1'b0, 8'hFF, 4'hF, 1'b0, 2'h0, ps, bu, 64'h0};
      // Run on past done so the acknowledge synchronisers drain before the next strobe
      for (i = 1; i < 40 && (td == 0 || i <= td + 4); i = i + 1) begin
        if (sel !== 8'hFF && ts == 0)
          ts = i;
        if (i == td + 1)
          hd = ad;
        if (done === 1'b1 && td == 0)
          td = i;
        {sl, wv, oe, dv} = {sl & sel, wv & we, oe | aoe, dv | dh};
        @(negedge clk);
      end
    end
  endtask
  // Transfer, then compare the selects seen
  task sel_is(input [31:0] a, input [4:0] t, input [7:0] e);
    begin
      xfer(a, t, 2'h2);
      chk("select", sl, e);
    end
  endtask
  // Boot select covers any address until the bank zero mask write
  task t_boot;
    begin
      chk("boot", boot, 1'b1);
      sel_is(32'h5000_0000, 5'h00, 8'hFE);
      chk("setup", ts, 32'h2);
      chk("hold", hd, 1'b1);
      m0wr = 1'b1;
      repeat (6) @(negedge clk);
      chk("boot", boot, 1'b0);
    end
  endtask
  // Direction and attribute permissions
  task t_perm;
    begin
      sel_is(32'h4000_0000, 5'h01, 8'hFF);
      sel_is(32'h4000_0000, 5'h00, 8'hEF);
      sel_is(32'h5000_0000, 5'h02, 8'hFF);
      sel_is(32'h5000_0000, 5'h00, 8'hDF);
      sel_is(32'h1000_0000, 5'h08, 8'hFD);
      atr[9] = 1'b1;
      sel_is(32'h1000_0000, 5'h08, 8'hFF);
    end
  endtask
  // Wait counts, setup and hold, write lanes on a 16-bit port
  task t_wait;
    begin
      for (n = 1; n < 4; n = n + 1) begin
        xfer({n[3:0], 28'h0}, 5'h00, 2'h2);
        chk("wait", td, n);
        chk("setup", ts, 32'h1);
      end
      chk("hold", hd, 1'b0);
      xfer(32'h7000_0000, 5'h01, 2'h2);
      chk("setup", ts, 32'h2);
      chk("hold", hd, 1'b1);
      xfer(32'h2000_0000, 5'h01, 2'h2);
      chk("we", wv, 4'h3);
      xfer(32'h2000_0001, 5'h01, 2'h1);
      chk("we", wv, 4'hB);
      chk("size", pz, `CSD_PS_16);
      xfer(32'h2000_0000, 5'h00, 2'h2);
      chk("we", wv, 4'hF);
    end
  endtask
  // Early ends by the far side, burst choice, external masters
  task t_ack;
    begin
      for (n = 2; n >= 0; n = n - 1) begin
        mode = n[1:0];
        xfer(32'h6000_0000, 5'h00, 2'h0);
        chk("early", td < 16, n != 0);
        chk("burst", bz, 1'b1);
      end
      chk("wait", td, 32'h10);
      xfer(32'h6000_0000, 5'h00, 2'h2);
      chk("burst", bz, 1'b0);
      xfer(32'h2000_0000, 5'h00, 2'h0);
      chk("burst", bz, 1'b0);
      mode = 2'h1;
      xfer(32'h6000_0000, 5'h10, 2'h2);
      chk("ack oe", oe, 1'b1);
      mode = 2'h2;
      xfer(32'h2000_0000, 5'h10, 2'h2);
      chk("ack oe", oe, 1'b0);
      mode = 2'h0;
    end
  endtask
  // Address match, masking, priority and default space
  task t_decode;
    begin
      sel_is(32'h0000_1234, 5'h00, 8'hFE);
      sel_is(32'h2003_0000, 5'h00, 8'hFB);
      sel_is(32'h3000_0000, 5'h00, 8'hF7);
      sel_is(32'h2004_0000, 5'h00, 8'hFF);
      chk("dflt ps", pz, `CSD_PS_8);
      sel_is(32'h9000_0000, 5'h00, 8'hFF);
      chk("dram", dv, 2'h2);
    end
  endtask
  // Verdict
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // Banks 1-3 wait 0-2, 4 read only, 5 masks supervisor data, 6 burst, 7 setup and hold
  initial begin
    {err_count, checks_done, rst_n, stb, m0wr, mode, at, sz, addr} = '0;
    base = 128'h7000_6000_5000_4000_3000_2000_1000_0000;
    ctl = {112'h1E66_19EF_1865_0863_1862_1861_1860, `CSD_BOOT_CTL};
    msk = 128'h3_0000_0000;
    atr = 40'h00_0200_0000;
    dctl = 16'h1852;
    dbase = 32'h9000_3000;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_boot;
    t_perm;
    t_wait;
    t_ack;
    t_decode;
    finish_test;
  end
  // Watchdog, several times the expected run
  initial begin
    #100000;
    err_count = err_count + 1;
    finish_test;
  end
endmodule // tb_top
